// file: bcfp_checker.sv
`timescale 1ns/1ps
module bcfp_checker (
	input logic clock,
	input logic arst_n,
	input logic port_a_clock,
	input logic port_a_chip_select_n,
	input logic port_a_transfer_enable,
	input logic port_a_write_select,
	input logic port_a_mailbox_select,
	input logic port_a_data_lines_oe_n,
	input logic port_a_empty_flag,
	input logic port_a_almost_empty_flag,
	input logic port_a_full_flag,
	input logic port_a_almost_full_flag,
	input logic port_b_clock,
	input logic port_b_chip_select_n,
	input logic port_b_transfer_enable,
	input logic port_b_write_select,
	input logic [1:0] port_b_bus_size,
	input logic [35:0] port_b_data_lines_out,
	input logic port_b_data_lines_oe_n,
	input logic port_b_empty_flag,
	input logic port_b_almost_empty_flag,
	input logic port_b_full_flag,
	input logic port_b_almost_full_flag,
	input logic mail_ab_flag_n
);
	// ****************************************
	// port edges seen since reset, saturating
	// ****************************************
	logic pa_q;
	logic pb_q;
	logic [1:0] na_q;
	logic [1:0] nb_q;
	wire edge_a = port_a_clock && !pa_q;
	wire edge_b = port_b_clock && !pb_q;
	wire [1:0] na_d = (edge_a && na_q != 2'h3) ? na_q + 2'h1 : na_q;
	wire [1:0] nb_d = (edge_b && nb_q != 2'h3) ? nb_q + 2'h1 : nb_q;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pa_q <= 1'h0;
			pb_q <= 1'h0;
			na_q <= 2'h0;
			nb_q <= 2'h0;
		end
		else
		begin
			pa_q <= port_a_clock;
			pb_q <= port_b_clock;
			na_q <= na_d;
			nb_q <= nb_d;
		end
	end

	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// a transfer taken at a port edge
	sequence a_take_s;
		!port_a_clock ##1 (port_a_clock && !port_a_chip_select_n && port_a_transfer_enable);
	endsequence
	sequence b_take_s;
		!port_b_clock ##1 (port_b_clock && !port_b_chip_select_n && port_b_transfer_enable);
	endsequence

	oe_port_a_a: assert property (port_a_data_lines_oe_n == $past(port_a_chip_select_n | port_a_write_select))
		else $error("port a drive enable wrong");
	oe_port_b_a: assert property (port_b_data_lines_oe_n == $past(port_b_chip_select_n | port_b_write_select))
		else $error("port b drive enable wrong");
	sync_flags_a_a: assert property (!$stable({port_a_empty_flag, port_a_almost_empty_flag, port_a_full_flag, port_a_almost_full_flag}) |-> $past(port_a_clock) && !$past(port_a_clock, 2))
		else $error("port a flag moved off a port edge");
	sync_flags_b_a: assert property (!$stable({port_b_empty_flag, port_b_almost_empty_flag, port_b_full_flag, port_b_almost_full_flag}) |-> $past(port_b_clock) && !$past(port_b_clock, 2))
		else $error("port b flag moved off a port edge");
	full_release_a_a: assert property (na_q == 2'h2 && $past(na_q) == 2'h1 |-> port_a_full_flag)
		else $error("port a full flag late after reset");
	full_release_b_a: assert property (nb_q == 2'h2 && $past(nb_q) == 2'h1 |-> port_b_full_flag)
		else $error("port b full flag late after reset");
	mail_store_a: assert property (a_take_s ##0 (port_a_write_select && port_a_mailbox_select && mail_ab_flag_n) |=> !mail_ab_flag_n)
		else $error("mail flag not set by write");
	mail_fetch_a: assert property (b_take_s ##0 (!port_b_write_select && port_b_bus_size == bcfp_pkg::BCFP_SIZE_MAIL && !mail_ab_flag_n) |=> mail_ab_flag_n)
		else $error("mail flag not cleared by read");
	empty_block_a: assert property (b_take_s ##0 (!port_b_write_select && port_b_bus_size != bcfp_pkg::BCFP_SIZE_MAIL && !port_b_empty_flag) |=> $stable(port_b_data_lines_out) [*2])
		else $error("read of empty queue changed data");
endmodule : bcfp_checker

// file: bcfp_fifo_pair.sv
`timescale 1ns/1ps
module bcfp_fifo_pair #(
	parameter int DEPTH = bcfp_pkg::BCFP_DEPTH,
	parameter int OFFSET0 = 8,
	parameter int OFFSET1 = 16,
	parameter int OFFSET2 = 4,
	parameter int OFFSET3 = 32
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic port_a_clock,
	input wire logic port_a_chip_select_n,
	input wire logic port_a_transfer_enable,
	input wire logic port_a_write_select,
	input wire logic port_a_mailbox_select,
	input wire logic port_a_parity_generate,
	input wire logic [35:0] port_a_data_lines_in,
	output logic [35:0] port_a_data_lines_out,
	output logic port_a_data_lines_oe_n,
	output logic port_a_empty_flag,
	output logic port_a_almost_empty_flag,
	output logic port_a_full_flag,
	output logic port_a_almost_full_flag,
	output logic port_a_parity_error_n,
	input wire logic port_b_clock,
	input wire logic port_b_chip_select_n,
	input wire logic port_b_transfer_enable,
	input wire logic port_b_write_select,
	input wire logic [1:0] port_b_bus_size,
	input wire logic [1:0] port_b_swap_mode,
	input wire logic endian_select,
	input wire logic port_b_parity_generate,
	input wire logic [35:0] port_b_data_lines_in,
	output logic [35:0] port_b_data_lines_out,
	output logic port_b_data_lines_oe_n,
	output logic port_b_empty_flag,
	output logic port_b_almost_empty_flag,
	output logic port_b_full_flag,
	output logic port_b_almost_full_flag,
	output logic port_b_parity_error_n,
	output logic mail_ab_flag_n,
	output logic mail_ba_flag_n,
	input wire logic odd_parity_select,
	input wire logic offset_select_low,
	input wire logic offset_select_high
);

	localparam int CW = $clog2(DEPTH) + 1;
	localparam int AW = CW - 1;

	// ****************************************
	// storage and state
	// ****************************************
	bcfp_pkg::bcfp_word_t a_to_b_queue [DEPTH];
	bcfp_pkg::bcfp_word_t b_to_a_queue [DEPTH];
	logic [CW-1:0] wp_ab_q, rp_ab_q, wp_ba_q, rp_ba_q;
	logic a_clk_q, b_clk_q;
	bcfp_pkg::bcfp_flags_t fa1_q, fa_q, fb1_q, fb_q;
	logic [6:0] thr_q;
	logic thr_done_q;
	bcfp_pkg::bcfp_word_t mail_ab_q, mail_ba_q, asm_q;
	logic mbf_ab_q, mbf_ba_q;
	logic [1:0] wpart_q, rpart_q;
	bcfp_pkg::bcfp_word_t a_out_q, b_out_q;
	logic a_oe_n_q, b_oe_n_q, a_perr_n_q, b_perr_n_q;

	// threshold chosen by the offset selects
	function automatic logic [6:0] pick_offset(input logic [1:0] sel);
		case (sel)
			2'h0: pick_offset = 7'(OFFSET0);
			2'h1: pick_offset = 7'(OFFSET1);
			2'h2: pick_offset = 7'(OFFSET2);
			default: pick_offset = 7'(OFFSET3);
		endcase
	endfunction : pick_offset

	// raw levels: rd_cnt of the queue read here, wr_cnt of the queue written here
	function automatic bcfp_pkg::bcfp_flags_t level(input logic [CW-1:0] rd_cnt,
		input logic [CW-1:0] wr_cnt, input logic [6:0] thr);
		logic [CW-1:0] free;
		bcfp_pkg::bcfp_flags_t f;
		free = CW'(DEPTH) - wr_cnt;
		f.empty = rd_cnt != '0;
		f.almost_empty = 7'(rd_cnt) > thr;
		f.full = free != '0;
		f.almost_full = 7'(free) > thr;
		level = f;
	endfunction : level

	// ****************************************
	// port strobes and decode
	// ****************************************
	// rising port clock edge seen on the system clock
	wire logic a_edge = port_a_clock & ~a_clk_q;
	wire logic b_edge = port_b_clock & ~b_clk_q;
	wire logic a_sel = a_edge & ~port_a_chip_select_n & port_a_transfer_enable;
	wire logic b_sel = b_edge & ~port_b_chip_select_n & port_b_transfer_enable;
	wire logic b_mbx = port_b_bus_size == bcfp_pkg::BCFP_SIZE_MAIL;
	wire logic a_wr = a_sel & port_a_write_select;
	wire logic a_rd = a_sel & ~port_a_write_select;
	wire logic b_wr = b_sel & port_b_write_select;
	wire logic b_rd = b_sel & ~port_b_write_select;
	wire logic push_ab = a_wr & ~port_a_mailbox_select & fa_q.full;
	wire logic pop_ba = a_rd & ~port_a_mailbox_select & fa_q.empty;
	wire logic b_wr_fifo = b_wr & ~b_mbx & fb_q.full;
	wire logic b_rd_fifo = b_rd & ~b_mbx & fb_q.empty;
	wire logic b_wlast = bcfp_pkg::bcfp_last(port_b_bus_size, wpart_q);
	wire logic b_rlast = bcfp_pkg::bcfp_last(port_b_bus_size, rpart_q);
	wire logic push_ba = b_wr_fifo & b_wlast;
	wire logic pop_ab = b_rd_fifo & b_rlast;
	wire logic mail_ab_wr = a_wr & port_a_mailbox_select & mbf_ab_q;
	wire logic mail_ba_wr = b_wr & b_mbx & mbf_ba_q;
	wire logic mail_ab_rd = b_rd & b_mbx;
	wire logic mail_ba_rd = a_rd & port_a_mailbox_select;

	// ****************************************
	// occupancy and flag levels
	// ****************************************
	// counts after this cycle's pushes and pops
	wire logic [CW-1:0] cnt_ab = wp_ab_q - rp_ab_q;
	wire logic [CW-1:0] cnt_ba = wp_ba_q - rp_ba_q;
	wire logic [CW-1:0] nxt_ab = CW'(cnt_ab + CW'(push_ab) - CW'(pop_ab));
	wire logic [CW-1:0] nxt_ba = CW'(cnt_ba + CW'(push_ba) - CW'(pop_ba));
	wire bcfp_pkg::bcfp_flags_t lvl_a = level(nxt_ba, nxt_ab, thr_q);
	wire bcfp_pkg::bcfp_flags_t lvl_b = level(nxt_ab, nxt_ba, thr_q);

	// ****************************************
	// port B lane handling and read data
	// ****************************************
	// sized bus part merged into the word, swapped into the queue
	wire bcfp_pkg::bcfp_word_t b_asm = bcfp_pkg::bcfp_insert(asm_q, port_b_data_lines_in,
		port_b_bus_size, endian_select, wpart_q);
	wire bcfp_pkg::bcfp_word_t b_wdata = bcfp_pkg::bcfp_swap(b_asm, port_b_swap_mode);
	wire bcfp_pkg::bcfp_word_t b_head = bcfp_pkg::bcfp_swap(a_to_b_queue[rp_ab_q[AW-1:0]],
		port_b_swap_mode);
	wire logic [3:0] b_mask = bcfp_pkg::bcfp_lane_mask(port_b_bus_size, endian_select);
	wire bcfp_pkg::bcfp_word_t b_part = bcfp_pkg::bcfp_extract(b_head, port_b_bus_size,
		endian_select, rpart_q);
	wire bcfp_pkg::bcfp_word_t b_rsrc = b_mbx ? mail_ab_q : b_part;
	wire bcfp_pkg::bcfp_word_t b_rdata = port_b_parity_generate ?
		bcfp_pkg::bcfp_parity_gen(b_rsrc, odd_parity_select, b_mask) : b_rsrc;
	wire bcfp_pkg::bcfp_word_t a_rsrc = port_a_mailbox_select ? mail_ba_q :
		b_to_a_queue[rp_ba_q[AW-1:0]];
	wire bcfp_pkg::bcfp_word_t a_rdata = port_a_parity_generate ?
		bcfp_pkg::bcfp_parity_gen(a_rsrc, odd_parity_select, 4'hf) : a_rsrc;

	// ****************************************
	// queue memories
	// ****************************************
	// array writes, no reset on storage
	always_ff @(posedge clock)
	begin
		if (push_ab)
			a_to_b_queue[wp_ab_q[AW-1:0]] <= port_a_data_lines_in;
		if (push_ba)
			b_to_a_queue[wp_ba_q[AW-1:0]] <= b_wdata;
	end

	// pointers and clock samples
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wp_ab_q <= '0;
			rp_ab_q <= '0;
			wp_ba_q <= '0;
			rp_ba_q <= '0;
			a_clk_q <= bcfp_pkg::BCFP_CLK_RST;
			b_clk_q <= bcfp_pkg::BCFP_CLK_RST;
		end
		else
		begin
			wp_ab_q <= CW'(wp_ab_q + CW'(push_ab));
			rp_ab_q <= CW'(rp_ab_q + CW'(pop_ab));
			wp_ba_q <= CW'(wp_ba_q + CW'(push_ba));
			rp_ba_q <= CW'(rp_ba_q + CW'(pop_ba));
			a_clk_q <= port_a_clock;
			b_clk_q <= port_b_clock;
		end
	end

	// ****************************************
	// offset capture
	// ****************************************
	// selects taken on the first clock after release
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			thr_q <= bcfp_pkg::BCFP_THR_RST;
			thr_done_q <= 1'b0;
		end
		else if (!thr_done_q)
		begin
			thr_q <= pick_offset({offset_select_high, offset_select_low});
			thr_done_q <= 1'b1;
		end
	end

	// ****************************************
	// flag synchronisers
	// ****************************************
	// rises pass both stages, falls take effect at once
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fa1_q <= bcfp_pkg::BCFP_FLAGS_RST;
			fa_q <= bcfp_pkg::BCFP_FLAGS_RST;
			fb1_q <= bcfp_pkg::BCFP_FLAGS_RST;
			fb_q <= bcfp_pkg::BCFP_FLAGS_RST;
		end
		else
		begin
			if (a_edge)
			begin
				fa1_q <= lvl_a;
				fa_q <= bcfp_pkg::bcfp_flags_t'(fa1_q & lvl_a);
			end
			if (b_edge)
			begin
				fb1_q <= lvl_b;
				fb_q <= bcfp_pkg::bcfp_flags_t'(fb1_q & lvl_b);
			end
		end
	end

	// ****************************************
	// mailboxes and port B part counters
	// ****************************************
	// new mail drives the flag low and wins over a read
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mail_ab_q <= bcfp_pkg::BCFP_WORD_RST;
			mail_ba_q <= bcfp_pkg::BCFP_WORD_RST;
			mbf_ab_q <= bcfp_pkg::BCFP_MAIL_FLAG_RST;
			mbf_ba_q <= bcfp_pkg::BCFP_MAIL_FLAG_RST;
			asm_q <= bcfp_pkg::BCFP_WORD_RST;
			wpart_q <= bcfp_pkg::BCFP_PART_RST;
			rpart_q <= bcfp_pkg::BCFP_PART_RST;
		end
		else
		begin
			if (mail_ab_wr)
				mail_ab_q <= port_a_data_lines_in;
			if (mail_ba_wr)
				mail_ba_q <= port_b_data_lines_in;
			mbf_ab_q <= mail_ab_wr ? 1'b0 : (mail_ab_rd ? 1'b1 : mbf_ab_q);
			mbf_ba_q <= mail_ba_wr ? 1'b0 : (mail_ba_rd ? 1'b1 : mbf_ba_q);
			if (b_wr_fifo)
			begin
				asm_q <= b_asm;
				wpart_q <= b_wlast ? bcfp_pkg::BCFP_PART_RST : 2'(wpart_q + 2'h1);
			end
			if (b_rd_fifo)
				rpart_q <= b_rlast ? bcfp_pkg::BCFP_PART_RST : 2'(rpart_q + 2'h1);
		end
	end

	// ****************************************
	// output registers and parity check
	// ****************************************
	// data loads on a read edge, drivers on while chip select and write select are low
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			a_out_q <= bcfp_pkg::BCFP_WORD_RST;
			b_out_q <= bcfp_pkg::BCFP_WORD_RST;
			a_oe_n_q <= bcfp_pkg::BCFP_OE_N_RST;
			b_oe_n_q <= bcfp_pkg::BCFP_OE_N_RST;
			a_perr_n_q <= bcfp_pkg::BCFP_PERR_N_RST;
			b_perr_n_q <= bcfp_pkg::BCFP_PERR_N_RST;
		end
		else
		begin
			if (pop_ba || mail_ba_rd)
				a_out_q <= a_rdata;
			if (b_rd_fifo || mail_ab_rd)
				b_out_q <= b_rdata;
			a_oe_n_q <= port_a_chip_select_n | port_a_write_select;
			b_oe_n_q <= port_b_chip_select_n | port_b_write_select;
			if (a_edge)
				a_perr_n_q <= ~bcfp_pkg::bcfp_parity_bad(port_a_data_lines_in,
					odd_parity_select, 4'hf);
			if (b_edge)
				b_perr_n_q <= ~bcfp_pkg::bcfp_parity_bad(port_b_data_lines_in,
					odd_parity_select, b_mask);
		end
	end

	// outputs straight from the registers
	assign port_a_data_lines_out = a_out_q;
	assign port_a_data_lines_oe_n = a_oe_n_q;
	assign port_b_data_lines_out = b_out_q;
	assign port_b_data_lines_oe_n = b_oe_n_q;
	assign port_a_empty_flag = fa_q.empty;
	assign port_a_almost_empty_flag = fa_q.almost_empty;
	assign port_a_full_flag = fa_q.full;
	assign port_a_almost_full_flag = fa_q.almost_full;
	assign port_b_empty_flag = fb_q.empty;
	assign port_b_almost_empty_flag = fb_q.almost_empty;
	assign port_b_full_flag = fb_q.full;
	assign port_b_almost_full_flag = fb_q.almost_full;
	assign port_a_parity_error_n = a_perr_n_q;
	assign port_b_parity_error_n = b_perr_n_q;
	assign mail_ab_flag_n = mbf_ab_q;
	assign mail_ba_flag_n = mbf_ba_q;

endmodule : bcfp_fifo_pair

// file: bcfp_pkg.sv
package bcfp_pkg;

	// ****************************************
	// widths, encodings and reset values
	// ****************************************
	localparam int BCFP_WIDTH = 36;
	localparam int BCFP_DEPTH = 64;
	localparam logic [1:0] BCFP_SIZE_LONG = 2'h0;
	localparam logic [1:0] BCFP_SIZE_WORD = 2'h1;
	localparam logic [1:0] BCFP_SIZE_BYTE = 2'h2;
	localparam logic [1:0] BCFP_SIZE_MAIL = 2'h3;
	localparam logic [1:0] BCFP_SWAP_NONE = 2'h0;
	localparam logic [1:0] BCFP_SWAP_FULL = 2'h1;
	localparam logic [1:0] BCFP_SWAP_PAIR = 2'h2;
	localparam logic [1:0] BCFP_SWAP_HALF = 2'h3;
	localparam logic [1:0] BCFP_PART_RST = 2'h0;
	localparam logic BCFP_MAIL_FLAG_RST = 1'h1;
	localparam logic BCFP_CLK_RST = 1'h0;
	localparam logic BCFP_OE_N_RST = 1'h1;
	localparam logic BCFP_PERR_N_RST = 1'h1;
	localparam logic [6:0] BCFP_THR_RST = 7'h00;
	localparam logic [35:0] BCFP_WORD_RST = 36'h0_0000_0000;

	typedef logic [35:0] bcfp_word_t;

	// port status flags, all high when the condition is absent
	typedef struct packed {
		logic empty;
		logic almost_empty;
		logic full;
		logic almost_full;
	} bcfp_flags_t;

	localparam bcfp_flags_t BCFP_FLAGS_RST = 4'h1;

	// ****************************************
	// lane helpers
	// ****************************************
	// byte-order swap, each mode is its own inverse
	function automatic bcfp_word_t bcfp_swap(input bcfp_word_t w, input logic [1:0] mode);
		case (mode)
			BCFP_SWAP_FULL: bcfp_swap = {w[8:0], w[17:9], w[26:18], w[35:27]};
			BCFP_SWAP_PAIR: bcfp_swap = {w[26:18], w[35:27], w[8:0], w[17:9]};
			BCFP_SWAP_HALF: bcfp_swap = {w[17:0], w[35:18]};
			default: bcfp_swap = w;
		endcase
	endfunction : bcfp_swap

	// last part of a long word for the given bus size
	function automatic logic bcfp_last(input logic [1:0] size, input logic [1:0] part);
		bcfp_last = (size == BCFP_SIZE_WORD) ? (part == 2'h1) :
			(size == BCFP_SIZE_BYTE) ? (part == 2'h3) : 1'b1;
	endfunction : bcfp_last

	// byte lanes used on the bus
	function automatic logic [3:0] bcfp_lane_mask(input logic [1:0] size, input logic endian);
		bcfp_lane_mask = (size == BCFP_SIZE_WORD) ? (endian ? 4'h3 : 4'hc) :
			(size == BCFP_SIZE_BYTE) ? (endian ? 4'h1 : 4'h8) : 4'hf;
	endfunction : bcfp_lane_mask

	// part of a word placed on the bus lanes
	function automatic bcfp_word_t bcfp_extract(input bcfp_word_t w, input logic [1:0] size,
		input logic endian, input logic [1:0] part);
		logic [17:0] half;
		logic [8:0] one;
		half = (endian ? part[0] : ~part[0]) ? w[35:18] : w[17:0];
		one = w[9 * int'(endian ? part : 2'h3 - part) +: 9];
		if (size == BCFP_SIZE_WORD)
			bcfp_extract = endian ? {18'h0_0000, half} : {half, 18'h0_0000};
		else if (size == BCFP_SIZE_BYTE)
			bcfp_extract = endian ? {27'h000_0000, one} : {one, 27'h000_0000};
		else
			bcfp_extract = w;
	endfunction : bcfp_extract

	// bus lanes merged into the word being assembled
	function automatic bcfp_word_t bcfp_insert(input bcfp_word_t w, input bcfp_word_t bus,
		input logic [1:0] size, input logic endian, input logic [1:0] part);
		logic [17:0] half;
		logic [8:0] one;
		bcfp_word_t r;
		half = endian ? bus[17:0] : bus[35:18];
		one = endian ? bus[8:0] : bus[35:27];
		r = w;
		if (size == BCFP_SIZE_WORD)
		begin
			if (endian ? part[0] : ~part[0])
				r[35:18] = half;
			else
				r[17:0] = half;
		end
		else if (size == BCFP_SIZE_BYTE)
			r[9 * int'(endian ? part : 2'h3 - part) +: 9] = one;
		else
			r = bus;
		bcfp_insert = r;
	endfunction : bcfp_insert

	// ****************************************
	// parity
	// ****************************************
	// write the parity of the low eight bits into the top bit of each used byte
	function automatic bcfp_word_t bcfp_parity_gen(input bcfp_word_t w, input logic odd,
		input logic [3:0] mask);
		bcfp_word_t r;
		r = w;
		for (int i = 0; i < 4; i++)
			if (mask[i])
				r[9 * i + 8] = (^w[9 * i +: 8]) ^ odd;
		bcfp_parity_gen = r;
	endfunction : bcfp_parity_gen

	// any used byte failing parity
	function automatic logic bcfp_parity_bad(input bcfp_word_t w, input logic odd,
		input logic [3:0] mask);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < 4; i++)
			if (mask[i] && ((^w[9 * i +: 9]) != odd))
				bad = 1'b1;
		bcfp_parity_bad = bad;
	endfunction : bcfp_parity_bad

endpackage : bcfp_pkg

// file: bcfp_port_host.sv
`timescale 1ns/1ps
module bcfp_port_host (
	input wire logic clock,
	output logic port_a_clock,
	output logic port_b_clock,
	input wire logic a_oe_n,
	input wire logic [35:0] a_out,
	input wire logic [35:0] a_drv,
	output logic [35:0] a_in,
	input wire logic b_oe_n,
	input wire logic [35:0] b_out,
	input wire logic [35:0] b_drv,
	output logic [35:0] b_in
);
	int ca = 0;
	int cb = 0;
	// free-running port clocks, periods of 4 and 6 clocks, moved on falling edges
	always @(negedge clock)
	begin
		ca <= (ca + 1) % 4;
		cb <= (cb + 1) % 6;
	end
	assign port_a_clock = ca >= 2;
	assign port_b_clock = cb >= 3;
	// wire level from whoever drives it
	assign a_in = a_oe_n ? a_drv : a_out;
	assign b_in = b_oe_n ? b_drv : b_out;
endmodule : bcfp_port_host

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	// ****************************************
	// signals
	// ****************************************
	localparam int THR = 12;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic a_cs_n = 1'h1, a_en = 1'h0, a_wr = 1'h0, a_mb = 1'h0;
	logic b_cs_n = 1'h1, b_en = 1'h0, b_wr = 1'h0, endian = 1'h0;
	logic [1:0] b_size = 2'h0, swap = 2'h0;
	bcfp_pkg::bcfp_word_t a_drv = 36'h0_0000_0000, b_drv = 36'h0_0000_0000;
	bcfp_pkg::bcfp_word_t a_in, b_in, a_out, b_out, w;
	wire bcfp_pkg::bcfp_flags_t fa, fb;
	logic pclk_a, pclk_b, a_oe_n, b_oe_n, pa_prev, pb_prev, mab_n, mba_n, pea_n, peb_n;
	int fail_count = 0, checks = 0, b_edges = 0, b_mark = 0;
	logic [31:0] seed = 32'h0000_00d0;
	bcfp_pkg::bcfp_word_t qa[$], qb[$], qm[$], model[$];
	always #5 clock = ~clock;

	bcfp_port_host host (.clock(clock), .port_a_clock(pclk_a), .port_b_clock(pclk_b),
		.a_oe_n(a_oe_n), .a_out(a_out), .a_drv(a_drv), .a_in(a_in),
		.b_oe_n(b_oe_n), .b_out(b_out), .b_drv(b_drv), .b_in(b_in));
	bcfp_fifo_pair #(.OFFSET1(THR)) dut (.clock(clock), .arst_n(arst_n),
		.port_a_clock(pclk_a), .port_a_chip_select_n(a_cs_n), .port_a_transfer_enable(a_en),
		.port_a_write_select(a_wr), .port_a_mailbox_select(a_mb), .port_a_parity_generate(1'h0),
		.port_a_data_lines_in(a_in), .port_a_data_lines_out(a_out), .port_a_data_lines_oe_n(a_oe_n),
		.port_a_empty_flag(fa.empty), .port_a_almost_empty_flag(fa.almost_empty),
		.port_a_full_flag(fa.full), .port_a_almost_full_flag(fa.almost_full),
		.port_a_parity_error_n(pea_n), .port_b_clock(pclk_b), .port_b_chip_select_n(b_cs_n),
		.port_b_transfer_enable(b_en), .port_b_write_select(b_wr), .port_b_bus_size(b_size),
		.port_b_swap_mode(swap), .endian_select(endian), .port_b_parity_generate(1'h0),
		.port_b_data_lines_in(b_in), .port_b_data_lines_out(b_out), .port_b_data_lines_oe_n(b_oe_n),
		.port_b_empty_flag(fb.empty), .port_b_almost_empty_flag(fb.almost_empty),
		.port_b_full_flag(fb.full), .port_b_almost_full_flag(fb.almost_full),
		.port_b_parity_error_n(peb_n), .mail_ab_flag_n(mab_n), .mail_ba_flag_n(mba_n),
		.odd_parity_select(1'h0), .offset_select_low(1'h1), .offset_select_high(1'h0));

	// ****************************************
	// helpers
	// ****************************************
	function automatic bcfp_pkg::bcfp_word_t rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		rnd = {seed[3:0], seed};
	endfunction : rnd
	// even parity holds in every byte
	function automatic logic par_ok(input bcfp_pkg::bcfp_word_t v);
		par_ok = ~|{^v[35:27], ^v[26:18], ^v[17:9], ^v[8:0]};
	endfunction : par_ok
	function automatic bcfp_pkg::bcfp_word_t swp(input bcfp_pkg::bcfp_word_t v, input logic [1:0] m);
		case (m)
			bcfp_pkg::BCFP_SWAP_FULL: swp = {v[8:0], v[17:9], v[26:18], v[35:27]};
			bcfp_pkg::BCFP_SWAP_PAIR: swp = {v[26:18], v[35:27], v[8:0], v[17:9]};
			bcfp_pkg::BCFP_SWAP_HALF: swp = {v[17:0], v[35:18]};
			default: swp = v;
		endcase
	endfunction : swp
	// part p of a word on the lanes picked by size and endian
	function automatic bcfp_pkg::bcfp_word_t place(input bcfp_pkg::bcfp_word_t v, input logic [1:0] sz,
		input logic e, input int p);
		place = (sz == bcfp_pkg::BCFP_SIZE_WORD || sz == bcfp_pkg::BCFP_SIZE_BYTE) ? 36'h0_0000_0000 : v;
		if (sz == bcfp_pkg::BCFP_SIZE_WORD && e)
			place[17:0] = v[18 * p +: 18];
		else if (sz == bcfp_pkg::BCFP_SIZE_WORD)
			place[35:18] = v[18 * (1 - p) +: 18];
		else if (sz == bcfp_pkg::BCFP_SIZE_BYTE && e)
			place[8:0] = v[9 * p +: 9];
		else if (sz == bcfp_pkg::BCFP_SIZE_BYTE)
			place[35:27] = v[9 * (3 - p) +: 9];
	endfunction : place
	task automatic cmp_data(input bcfp_pkg::bcfp_word_t g, input bcfp_pkg::bcfp_word_t e,
		input bcfp_pkg::bcfp_word_t m);
		checks++;
		if ((g & m) !== (e & m))
		begin
			fail_count++;
			$display("Error at %0t: data %h, expected %h", $time, g, e);
		end
	endtask : cmp_data
	task automatic cmp_flag(input logic [11:0] g, input logic [11:0] e);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error at %0t: flags %h, expected %h", $time, g, e);
		end
	endtask : cmp_flag
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic wait_empty(input logic on_a);
		int n;
		n = 0;
		while ((on_a ? fa.empty : fb.empty) !== 1'h1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		if (n == 200)
		begin
			fail_count++;
			$display("Error at %0t: empty flag never rose", $time);
			stop_test();
		end
	endtask : wait_empty
	// one transfer held across one port edge
	task automatic xa(input logic wr, input logic mb, input bcfp_pkg::bcfp_word_t d);
		@(posedge pclk_a);
		a_cs_n = 1'h0;
		a_en = 1'h1;
		a_wr = wr;
		a_mb = mb;
		a_drv = d;
		@(posedge clock);
		b_mark = b_edges;
		@(negedge clock);
		a_cs_n = 1'h1;
		a_en = 1'h0;
		@(negedge clock);
	endtask : xa
	task automatic xb(input logic wr, input bcfp_pkg::bcfp_word_t d);
		@(posedge pclk_b);
		b_cs_n = 1'h0;
		b_en = 1'h1;
		b_wr = wr;
		b_drv = d;
		@(posedge clock);
		@(negedge clock);
		b_cs_n = 1'h1;
		b_en = 1'h0;
		@(negedge clock);
	endtask : xb
	// a whole word on port b, noting each part read
	task automatic b_word(input logic wr, input bcfp_pkg::bcfp_word_t v);
		int n;
		n = b_size == bcfp_pkg::BCFP_SIZE_WORD ? 2 : b_size == bcfp_pkg::BCFP_SIZE_BYTE ? 4 : 1;
		for (int p = 0; p < n; p++)
		begin
			if (!wr)
			begin
				qb.push_back(place(swp(v, swap), b_size, endian, p));
				qm.push_back(place(36'hf_ffff_ffff, b_size, endian, p));
			end
			xb(wr, place(v, b_size, endian, p));
		end
	endtask : b_word

	// ****************************************
	// result watchers
	// ****************************************
	always @(posedge clock)
	begin
		pa_prev <= pclk_a;
		pb_prev <= pclk_b;
		if (pclk_b && !pb_prev)
			b_edges <= b_edges + 1;
	end
	always @(posedge clock)
		if (pclk_a && !pa_prev && !a_cs_n && a_en && !a_wr && (a_mb || fa.empty))
		begin
			@(negedge clock);
			@(negedge clock);
			cmp_data(a_out, qa.pop_front(), 36'hf_ffff_ffff);
		end
	always @(posedge clock)
		if (pclk_b && !pb_prev && !b_cs_n && b_en && !b_wr && (b_size == 2'h3 || fb.empty))
		begin
			@(negedge clock);
			@(negedge clock);
			cmp_data(b_out, qb.pop_front(), qm.pop_front());
		end

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		repeat (30) @(negedge clock);
		cmp_flag({fa, fb, mab_n, mba_n, a_oe_n, b_oe_n}, 12'h11f);
		arst_n = 1'h1;
		repeat (20) @(negedge clock);
		cmp_flag({fa, fb}, 12'h033);
		$display("test reset done");
		for (int i = 1; i <= bcfp_pkg::BCFP_DEPTH + 1; i++)
		begin
			w = rnd();
			xa(1'h1, 1'h0, w);
			if (i <= bcfp_pkg::BCFP_DEPTH)
				model.push_back(w);
			if (i == 1)
				wait_empty(1'h0);
			if (i == 1)
				cmp_flag(b_edges - b_mark, 12'h002);
			cmp_flag({fa.full, fa.almost_full}, {i < bcfp_pkg::BCFP_DEPTH, bcfp_pkg::BCFP_DEPTH - i > THR});
		end
		repeat (30) @(negedge clock);
		cmp_flag({fb.empty, fb.almost_empty}, 12'h003);
		$display("test fill done");
		for (int i = bcfp_pkg::BCFP_DEPTH - 1; i >= 0; i--)
		begin
			w = model.pop_front();
			b_word(1'h0, w);
			cmp_flag({fb.empty, fb.almost_empty}, {i > 0, i > THR});
		end
		xb(1'h0, 36'h0_0000_0000);
		cmp_data(b_out, w, 36'hf_ffff_ffff);
		$display("test drain done");
		for (int k = 0; k < 24; k++)
		begin
			b_size = k < 8 ? bcfp_pkg::BCFP_SIZE_WORD : k < 16 ? bcfp_pkg::BCFP_SIZE_BYTE : bcfp_pkg::BCFP_SIZE_LONG;
			endian = k[2];
			swap = k[1:0];
			w = rnd();
			xa(1'h1, 1'h0, w);
			wait_empty(1'h0);
			b_word(1'h0, w);
			w = rnd();
			b_word(1'h1, w);
			wait_empty(1'h1);
			qa.push_back(swp(w, swap));
			xa(1'h0, 1'h0, 36'h0_0000_0000);
		end
		$display("test sizing done");
		b_size = bcfp_pkg::BCFP_SIZE_MAIL;
		swap = bcfp_pkg::BCFP_SWAP_NONE;
		w = rnd();
		xa(1'h1, 1'h1, w);
		cmp_flag(mab_n, 12'h000);
		cmp_flag(pea_n, par_ok(w));
		b_word(1'h0, w);
		cmp_flag(mab_n, 12'h001);
		w = rnd();
		b_word(1'h1, w);
		cmp_flag(mba_n, 12'h000);
		cmp_flag(peb_n, par_ok(w));
		qa.push_back(w);
		xa(1'h0, 1'h1, 36'h0_0000_0000);
		cmp_flag(mba_n, 12'h001);
		$display("test mailbox done");
		repeat (10) @(negedge clock);
		stop_test();
	end
endmodule : testbench

bind bcfp_fifo_pair bcfp_checker chk (.*);
